// *** calr_pkg.sv ***
package calr_pkg;

  localparam int unsigned CALR_MAX_CH = 8;
  localparam int unsigned CALR_SET_BYTES = 5;
  localparam int unsigned CALR_IDX_W = 3;

  localparam logic [7:0] CALR_CH0_DEADBAND_OFS = 8'h15;
  localparam logic [7:0] CALR_CH0_HIGH_UPPER_OFS = 8'h16;
  localparam logic [7:0] CALR_CH0_HIGH_LOWER_OFS = 8'h17;
  localparam logic [7:0] CALR_CH0_LOW_UPPER_OFS = 8'h18;
  localparam logic [7:0] CALR_CH0_LOW_LOWER_OFS = 8'h19;
  localparam logic [7:0] CALR_SET_STRIDE = 8'h05;
  localparam logic [7:0] CALR_LAST_OFS = 8'h3c;

  localparam logic [2:0] CALR_IDX_DEADBAND = 3'h0;
  localparam logic [2:0] CALR_IDX_HIGH_UPPER = 3'h1;
  localparam logic [2:0] CALR_IDX_HIGH_LOWER = 3'h2;
  localparam logic [2:0] CALR_IDX_LOW_UPPER = 3'h3;
  localparam logic [2:0] CALR_IDX_LOW_LOWER = 3'h4;

  localparam logic [7:0] CALR_DEADBAND_RST = 8'h00;
  localparam logic [7:0] CALR_HIGH_RST = 8'h01;
  localparam logic [7:0] CALR_LOW_RST = 8'h00;
  localparam logic [7:0] CALR_ABSENT_READ = 8'hff;
  localparam logic [7:0] CALR_UNMAPPED_READ = 8'h00;

  localparam logic [7:0] CALR_SET_RST [CALR_SET_BYTES] = '{
    CALR_DEADBAND_RST, CALR_HIGH_RST, CALR_HIGH_RST, CALR_LOW_RST, CALR_LOW_RST
  };

endpackage : calr_pkg

// *** calr_chan_set.sv ***
`timescale 1ns/10ps
module calr_chan_set
  import calr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [2:0] byteIdx,
  input wire logic [7:0] wrData,
  output logic [7:0] rdByte,
  output logic [7:0] chanAlarmDeadband,
  output logic [15:0] chanHighAlarmLimit,
  output logic [15:0] chanLowAlarmLimit
);

  logic [7:0] setByte_q [CALR_SET_BYTES];

  // One byte per entry; every byte value is stored as written.
  for (genvar i = 0; i < CALR_SET_BYTES; i++)
  begin : g_byte
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
      if (!arst_n)
        setByte_q[i] <= CALR_SET_RST[i];
      else if (clkEn && wrEn && byteIdx == 3'(i))
        setByte_q[i] <= wrData;
    end
  end

  always_comb
  begin
    rdByte = CALR_UNMAPPED_READ;
    if (byteIdx < 3'(CALR_SET_BYTES))
      rdByte = setByte_q[byteIdx];
  end

  assign chanAlarmDeadband = setByte_q[CALR_IDX_DEADBAND];
  // Upper byte is bits 15:8, lower byte bits 7:0.
  assign chanHighAlarmLimit = {setByte_q[CALR_IDX_HIGH_UPPER], setByte_q[CALR_IDX_HIGH_LOWER]};
  assign chanLowAlarmLimit = {setByte_q[CALR_IDX_LOW_UPPER], setByte_q[CALR_IDX_LOW_LOWER]};

endmodule : calr_chan_set

// *** calr_alarm_eval.sv ***
`timescale 1ns/10ps
module calr_alarm_eval
  import calr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire logic [15:0] sampleCode,
  input wire logic [7:0] chanAlarmDeadband,
  input wire logic [15:0] chanHighAlarmLimit,
  input wire logic [15:0] chanLowAlarmLimit,
  output logic highAlarm_q,
  output logic lowAlarm_q
);

  logic [16:0] sampleUp;
  logic [16:0] lowRelease;

  // Seventeen bits keep the deadband sums from wrapping near full scale.
  assign sampleUp = {1'b0, sampleCode} + {9'h000, chanAlarmDeadband};
  assign lowRelease = {1'b0, chanLowAlarmLimit} + {9'h000, chanAlarmDeadband};

  // High alarm releases only once the sample is the deadband below the limit.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      highAlarm_q <= 1'b0;
    else if (clkEn && sampleValid)
    begin
      if (!highAlarm_q)
        highAlarm_q <= sampleCode > chanHighAlarmLimit;
      else
        highAlarm_q <= sampleUp > {1'b0, chanHighAlarmLimit};
    end
  end

  // Low alarm uses the same deadband, mirrored above the low limit.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      lowAlarm_q <= 1'b0;
    else if (clkEn && sampleValid)
    begin
      if (!lowAlarm_q)
        lowAlarm_q <= sampleCode < chanLowAlarmLimit;
      else
        lowAlarm_q <= {1'b0, sampleCode} < lowRelease;
    end
  end

  chk_no_deadband: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && sampleValid && chanAlarmDeadband == 8'h00)
    |=> (highAlarm_q == ($past(sampleCode) > $past(chanHighAlarmLimit))))
    else $error("High alarm does not follow the plain limit with zero deadband.");

  chk_high_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && sampleValid && highAlarm_q && sampleUp > {1'b0, chanHighAlarmLimit})
    |=> highAlarm_q)
    else $error("High alarm released inside the deadband.");

  chk_low_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && sampleValid && lowAlarm_q && {1'b0, sampleCode} < lowRelease)
    ##1 !lowAlarm_q |-> 1'b0)
    else $error("Low alarm released inside the deadband.");

endmodule : calr_alarm_eval

// *** calr_limit_regs.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Hysteresis byte N gives a symmetric deadband of N LSB, 1 to 255.
// - A hysteresis byte of zero means alarms use the plain limits.
// - One hysteresis value serves both the high and the low alarm.
// - Channel 0 hysteresis lives at address 15h, all eight bits.
// - The high limit upper byte supplies threshold bits 15 to 8.
// - The high limit lower byte supplies threshold bits 7 to 0.
// - Channel 0 high limit upper byte at 16h, lower byte at 17h.
// - Every byte value 00h to FFh is accepted and used unchanged.
// - One register set per channel, eight or four channels by variant.
// - All are read/write; hysteresis resets to 0h, high limit bytes to 1h.
// - Each channel holds five consecutive bytes: hysteresis, high, then low limit.
// - The four-channel variant has no sets for channels 4 to 7.
module calr_limit_regs
  import calr_pkg::*;
#(
  parameter int unsigned NumChannels = CALR_MAX_CH
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire logic [2:0] sampleChan,
  input wire logic [15:0] sampleCode,
  output logic [CALR_MAX_CH-1:0] highAlarm,
  output logic [CALR_MAX_CH-1:0] lowAlarm
);

  logic [CALR_MAX_CH-1:0] chanHit;
  logic [2:0] chanIdx [CALR_MAX_CH];
  logic [7:0] chanRdByte [CALR_MAX_CH];
  logic [7:0] chanAlarmDeadband [CALR_MAX_CH];
  logic [15:0] chanHighAlarmLimit [CALR_MAX_CH];
  logic [15:0] chanLowAlarmLimit [CALR_MAX_CH];
  logic [7:0] rdMux;
  logic [7:0] rdData_q;
  logic firstCycle_q;

  // Sets follow each other with no gap, five bytes apart.
  for (genvar ch = 0; ch < CALR_MAX_CH; ch++)
  begin : g_chan
    localparam logic [7:0] SetBase = CALR_CH0_DEADBAND_OFS + 8'(CALR_SET_STRIDE * ch);
    logic [7:0] addrDelta;

    assign addrDelta = regAddr - SetBase;
    assign chanHit[ch] = regAddr >= SetBase && addrDelta < 8'(CALR_SET_BYTES);
    assign chanIdx[ch] = addrDelta[2:0];

    if (ch < NumChannels)
    begin : g_present
      calr_chan_set u_set (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .wrEn(regWrStrobe && chanHit[ch]),
        .byteIdx(chanIdx[ch]),
        .wrData(regWrData),
        .rdByte(chanRdByte[ch]),
        .chanAlarmDeadband(chanAlarmDeadband[ch]),
        .chanHighAlarmLimit(chanHighAlarmLimit[ch]),
        .chanLowAlarmLimit(chanLowAlarmLimit[ch])
      );

      calr_alarm_eval u_eval (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .sampleValid(sampleValid && sampleChan == 3'(ch)),
        .sampleCode(sampleCode),
        .chanAlarmDeadband(chanAlarmDeadband[ch]),
        .chanHighAlarmLimit(chanHighAlarmLimit[ch]),
        .chanLowAlarmLimit(chanLowAlarmLimit[ch]),
        .highAlarm_q(highAlarm[ch]),
        .lowAlarm_q(lowAlarm[ch])
      );

      // Every byte must land in, and read back from, its own slot of this set.
      chk_set_deadband: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regWrStrobe && regAddr == SetBase)
        |=> chanAlarmDeadband[ch] == $past(regWrData))
        else $error("Hysteresis write missed its channel.");

      chk_set_high_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regWrStrobe && regAddr == SetBase + 8'h01)
        |=> chanHighAlarmLimit[ch][15:8] == $past(regWrData))
        else $error("High limit upper byte missed bits 15 to 8 of its channel.");

      chk_set_high_lower: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regWrStrobe && regAddr == SetBase + 8'h02)
        |=> chanHighAlarmLimit[ch][7:0] == $past(regWrData))
        else $error("High limit lower byte missed bits 7 to 0 of its channel.");

      chk_set_low_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regWrStrobe && regAddr == SetBase + 8'h03)
        |=> chanLowAlarmLimit[ch][15:8] == $past(regWrData))
        else $error("Low limit upper byte missed its slot.");

      chk_set_low_lower: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regWrStrobe && regAddr == SetBase + 8'h04)
        |=> chanLowAlarmLimit[ch][7:0] == $past(regWrData))
        else $error("Low limit lower byte missed its slot.");

      // Writes elsewhere, or with the clock enable low, must leave the whole set alone.
      chk_set_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(clkEn && regWrStrobe && chanHit[ch])
        |=> ($stable(chanAlarmDeadband[ch]) && $stable(chanHighAlarmLimit[ch])
          && $stable(chanLowAlarmLimit[ch])))
        else $error("Register set changed without a write to it.");

      chk_read_deadband: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && regAddr == SetBase)
        |=> regRdData == $past(chanAlarmDeadband[ch]))
        else $error("Hysteresis read back differs from the stored byte.");

      chk_read_high_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && regAddr == SetBase + 8'h01)
        |=> regRdData == $past(chanHighAlarmLimit[ch][15:8]))
        else $error("High limit upper byte read from the wrong slot.");

      chk_read_high_lower: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && regAddr == SetBase + 8'h02)
        |=> regRdData == $past(chanHighAlarmLimit[ch][7:0]))
        else $error("High limit lower byte read from the wrong slot.");

      chk_read_low_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && regAddr == SetBase + 8'h03)
        |=> regRdData == $past(chanLowAlarmLimit[ch][15:8]))
        else $error("Low limit upper byte read from the wrong slot.");

      chk_read_low_lower: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && regAddr == SetBase + 8'h04)
        |=> regRdData == $past(chanLowAlarmLimit[ch][7:0]))
        else $error("Low limit lower byte read from the wrong slot.");

      // Alarm decisions as seen at the pins, one sample per channel.
      chk_alarm_set_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && sampleValid && sampleChan == 3'(ch) && !highAlarm[ch]
          && sampleCode > chanHighAlarmLimit[ch])
        |=> highAlarm[ch])
        else $error("High alarm missed a sample above the limit.");

      chk_alarm_drop_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && sampleValid && sampleChan == 3'(ch) && highAlarm[ch]
          && {1'b0, sampleCode} + {9'h000, chanAlarmDeadband[ch]} <= {1'b0, chanHighAlarmLimit[ch]})
        |=> !highAlarm[ch])
        else $error("High alarm held past the deadband.");

      chk_alarm_set_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && sampleValid && sampleChan == 3'(ch) && !lowAlarm[ch]
          && sampleCode < chanLowAlarmLimit[ch])
        |=> lowAlarm[ch])
        else $error("Low alarm missed a sample below the limit.");

      chk_alarm_drop_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && sampleValid && sampleChan == 3'(ch) && lowAlarm[ch]
          && {1'b0, sampleCode} >= {1'b0, chanLowAlarmLimit[ch]} + {9'h000, chanAlarmDeadband[ch]})
        |=> !lowAlarm[ch])
        else $error("Low alarm held past the deadband.");

      chk_alarm_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(clkEn && sampleValid && sampleChan == 3'(ch))
        |=> ($stable(highAlarm[ch]) && $stable(lowAlarm[ch])))
        else $error("Alarm moved without a sample for its channel.");
    end
    else
    begin : g_absent
      // Missing channels swallow writes and read back as all ones.
      assign chanRdByte[ch] = CALR_ABSENT_READ;
      assign chanAlarmDeadband[ch] = CALR_DEADBAND_RST;
      assign chanHighAlarmLimit[ch] = {CALR_HIGH_RST, CALR_HIGH_RST};
      assign chanLowAlarmLimit[ch] = {CALR_LOW_RST, CALR_LOW_RST};
      assign highAlarm[ch] = 1'b0;
      assign lowAlarm[ch] = 1'b0;

      chk_absent_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clkEn && regRdStrobe && chanHit[ch])
        |=> regRdData == CALR_ABSENT_READ)
        else $error("Register of a missing channel did not read as all ones.");
    end
  end

  // Addresses outside every set read as zero.
  always_comb
  begin
    rdMux = CALR_UNMAPPED_READ;
    for (int ch = 0; ch < CALR_MAX_CH; ch++)
    begin
      if (chanHit[ch])
        rdMux = chanRdByte[ch];
    end
  end

  // Read data stand only until the next enabled edge after the strobe, so stale bytes never linger while the clock enable is high.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdData_q <= CALR_UNMAPPED_READ;
    else if (clkEn)
      rdData_q <= regRdStrobe ? rdMux : CALR_UNMAPPED_READ;
  end

  assign regRdData = rdData_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      firstCycle_q <= 1'b1;
    else if (clkEn)
      firstCycle_q <= 1'b0;
  end

  chk_reset_defaults: assert property (@(posedge sys_clk) disable iff (!arst_n)
    firstCycle_q |-> (chanAlarmDeadband[0] == CALR_DEADBAND_RST
      && chanHighAlarmLimit[0] == {CALR_HIGH_RST, CALR_HIGH_RST}
      && chanLowAlarmLimit[0] == {CALR_LOW_RST, CALR_LOW_RST}
      && regRdData == CALR_UNMAPPED_READ))
    else $error("Register set left reset with wrong values.");

  chk_deadband_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr == CALR_CH0_DEADBAND_OFS)
    |=> chanAlarmDeadband[0] == $past(regWrData))
    else $error("Write at the channel 0 hysteresis address did not land.");

  chk_high_upper: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr == CALR_CH0_HIGH_UPPER_OFS)
    |=> (chanHighAlarmLimit[0][15:8] == $past(regWrData)
      && chanHighAlarmLimit[0][7:0] == $past(chanHighAlarmLimit[0][7:0])))
    else $error("High limit upper byte not placed in bits 15 to 8.");

  chk_high_lower: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr == CALR_CH0_HIGH_LOWER_OFS)
    |=> (chanHighAlarmLimit[0][7:0] == $past(regWrData)
      && chanHighAlarmLimit[0][15:8] == $past(chanHighAlarmLimit[0][15:8])))
    else $error("High limit lower byte not placed in bits 7 to 0.");

  chk_write_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr >= CALR_CH0_DEADBAND_OFS
      && regAddr < CALR_CH0_DEADBAND_OFS + 8'(CALR_SET_STRIDE * NumChannels)
      ##1 clkEn && regRdStrobe && regAddr == $past(regAddr))
    |=> regRdData == $past(regWrData, 2))
    else $error("Read back differs from the byte just written.");

  chk_byte_unchanged: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr == CALR_CH0_HIGH_LOWER_OFS && regWrData == 8'hff)
    ##1 (clkEn && regRdStrobe && regAddr == CALR_CH0_HIGH_LOWER_OFS)
    |=> regRdData == 8'hff)
    else $error("Full-scale threshold byte was altered.");

  chk_low_set_order: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regWrStrobe && regAddr == CALR_CH0_LOW_UPPER_OFS + CALR_SET_STRIDE)
    |=> chanLowAlarmLimit[1][15:8] == $past(regWrData))
    else $error("Channel 1 low limit upper byte not at its consecutive slot.");

  chk_last_chan_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (NumChannels == CALR_MAX_CH && clkEn && regWrStrobe
      && regAddr == CALR_LAST_OFS - 8'h04)
    |=> chanAlarmDeadband[CALR_MAX_CH-1] == $past(regWrData))
    else $error("Last channel hysteresis write did not land.");

  chk_absent_reads: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regRdStrobe && regAddr <= CALR_LAST_OFS
      && regAddr >= CALR_CH0_DEADBAND_OFS + 8'(CALR_SET_STRIDE * NumChannels))
    |=> regRdData == CALR_ABSENT_READ)
    else $error("Absent channel register did not read as all ones.");

  chk_read_window: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && !regRdStrobe) |=> regRdData == CALR_UNMAPPED_READ)
    else $error("Read data lingered past its single cycle.");

  chk_shared_deadband: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && sampleValid && sampleChan == 3'h0 && lowAlarm[0]
      && {1'b0, sampleCode} < {1'b0, chanLowAlarmLimit[0]} + {9'h000, chanAlarmDeadband[0]})
    |=> lowAlarm[0])
    else $error("Low alarm ignored the channel deadband.");

  chk_single_hit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $onehot0(chanHit))
    else $error("An address fell into two register sets.");

  chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkEn && regRdStrobe && (regAddr < CALR_CH0_DEADBAND_OFS || regAddr > CALR_LAST_OFS))
    |=> regRdData == CALR_UNMAPPED_READ)
    else $error("Address outside every set did not read as zero.");

  // A low clock enable is a full freeze, so a stalled host still sees its last answer.
  chk_frozen_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !clkEn |=> $stable(regRdData))
    else $error("Read data moved while the clock enable was low.");

  chk_frozen_alarms: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !clkEn
    |=> ($stable(highAlarm) && $stable(lowAlarm)))
    else $error("Alarms moved while the clock enable was low.");

endmodule : calr_limit_regs

// *** test_calr_limit_regs.sv ***
`timescale 1ns/10ps
module test_calr_limit_regs;
  import calr_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic sampleValid = 1'b0;
  logic [2:0] sampleChan = 3'h0;
  logic [15:0] sampleCode = 16'h0000;
  logic [7:0] rdData;
  logic [7:0] rdDataFour;
  logic [7:0] highAlarm;
  logic [7:0] lowAlarm;
  logic [7:0] highAlarmFour;
  logic [7:0] lowAlarmFour;
  int num_errors = 0;
  int checks_done = 0;
  logic rdPend = 1'b0;
  logic [7:0] rdExp8 = 8'h00;
  logic [7:0] rdExp4 = 8'h00;
  // Samples for channel 0: the first six run with a deadband of 4, the rest with none.
  logic [15:0] codes [10] = '{16'hab00, 16'haafc, 16'haafb, 16'h0fff, 16'h1003, 16'h1004,
                              16'hab00, 16'haaff, 16'h0fff, 16'h1000};
  logic [1:0] expHighLow [10] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b00, 2'b01, 2'b00};

  always #20 sys_clk = ~sys_clk;

  calr_limit_regs #(.NumChannels(8)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(rdData), .sampleValid(sampleValid), .sampleChan(sampleChan), .sampleCode(sampleCode),
    .highAlarm(highAlarm), .lowAlarm(lowAlarm));

  // The four-channel variant shares every input so both can be compared on one access.
  calr_limit_regs #(.NumChannels(4)) uutFour (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(rdDataFour), .sampleValid(sampleValid), .sampleChan(sampleChan), .sampleCode(sampleCode),
    .highAlarm(highAlarmFour), .lowAlarm(lowAlarmFour));

  task automatic check_val(input logic [7:0] seen, input logic [7:0] expected);
    checks_done++;
    if (seen !== expected)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check_val

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Each access task starts right after an edge and ends on the edge that takes it, so calls run back to back.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    regAddr <= addr;
    regWrData <= data;
    regRdStrobe <= 1'b0;
    regWrStrobe <= 1'b1;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp8, input logic [7:0] exp4);
    regAddr <= addr;
    regWrStrobe <= 1'b0;
    regRdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdExp8 = exp8;
    rdExp4 = exp4;
    rdPend = 1'b1;
  endtask : rd

  task automatic smp(input logic [2:0] chan, input logic [15:0] code);
    regWrStrobe <= 1'b0;
    regRdStrobe <= 1'b0;
    sampleValid <= 1'b1;
    sampleChan <= chan;
    sampleCode <= code;
    @(posedge sys_clk);
  endtask : smp

  task automatic idle();
    regWrStrobe <= 1'b0;
    regRdStrobe <= 1'b0;
    sampleValid <= 1'b0;
    @(posedge sys_clk);
  endtask : idle

  // Read data stand only in the cycle after the strobe; mid-cycle they are settled.
  always @(negedge sys_clk)
  begin
    if (rdPend)
    begin
      check_val(rdData, rdExp8);
      check_val(rdDataFour, rdExp4);
      rdPend = 1'b0;
    end
    else if (arst_n)
      check_val(rdData, 8'h00);
  end

  function automatic logic [7:0] pattern(input int a);
    return 8'(a * 7) ^ 8'ha5;
  endfunction : pattern

  initial
  begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 40; a++)
      rd(8'h15 + 8'(a), CALR_SET_RST[a % 5], (a < 20) ? CALR_SET_RST[a % 5] : 8'hff);
    rd(8'h14, 8'h00, 8'h00);
    rd(8'h3d, 8'h00, 8'h00);
    for (int a = 0; a < 40; a++)
      wr(8'h15 + 8'(a), pattern(a));
    for (int a = 0; a < 40; a++)
      rd(8'h15 + 8'(a), pattern(a), (a < 20) ? pattern(a) : 8'hff);
    wr(8'h16, 8'hff);
    wr(8'h17, 8'h00);
    rd(8'h16, 8'hff, 8'hff);
    rd(8'h17, 8'h00, 8'h00);
    // A strobe with the clock enable low must leave the register untouched.
    clkEn <= 1'b0;
    wr(8'h15, 8'h33);
    idle();
    clkEn <= 1'b1;
    rd(8'h15, pattern(0), pattern(0));
    wr(8'h15, 8'h04);
    rd(8'h15, 8'h04, 8'h04);
    wr(8'h16, 8'haa);
    wr(8'h17, 8'hff);
    rd(8'h17, 8'hff, 8'hff);
    wr(8'h18, 8'h10);
    wr(8'h19, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      if (i == 6)
        wr(8'h15, 8'h00);
      smp(3'h0, codes[i]);
      idle();
      check_val({6'h00, highAlarm[0], lowAlarm[0]}, {6'h00, expHighLow[i]});
      check_val({6'h00, highAlarmFour[0], lowAlarmFour[0]}, {6'h00, expHighLow[i]});
    end
    smp(3'h5, 16'hffff);
    idle();
    check_val({7'h00, highAlarm[5]}, 8'h01);
    check_val({highAlarmFour[7:4], lowAlarmFour[7:4]}, 8'h00);
    print_verdict();
  end

  // The sequence needs well under a thousand cycles; ten thousand means a hang.
  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule : test_calr_limit_regs
